/* hdl/wctc_pkg.sv */
// Package of register offsets, field positions, modes and constants for the timer control block.
package wctc_pkg;
    // Register byte offsets on the AHB-Lite bus.
    localparam logic [7:0] CTRL_A_OFF    = 8'h00;
    localparam logic [7:0] CTRL_B_OFF    = 8'h04;
    localparam logic [7:0] CMP_A_OFF     = 8'h08;
    localparam logic [7:0] CMP_B_OFF     = 8'h0C;
    localparam logic [7:0] CAPT_OFF      = 8'h10;
    localparam logic [7:0] COUNT_OFF     = 8'h14;
    localparam logic [7:0] FLAGS_OFF     = 8'h18;
    // Field positions in control register A and B.
    localparam int MODE_A_HI  = 7;
    localparam int MODE_B_HI  = 5;
    localparam int FILT_BIT   = 7;
    localparam int EDGE_BIT   = 6;
    localparam int WGM_H_HI   = 4;
    localparam int PRE_HI     = 2;
    // Bits that software can write; reserved bits stay zero.
    localparam logic [7:0] CTRL_A_WMASK  = 8'hF3;
    localparam logic [7:0] CTRL_B_WMASK  = 8'hDF;
    localparam logic [7:0] CTRL_RESET    = 8'h00;
    // Flag bit positions in the flag register.
    localparam int FLAG_CAPT  = 5;
    localparam int FLAG_CMPB  = 2;
    localparam int FLAG_CMPA  = 1;
    localparam int FLAG_OVF   = 0;
    // Fixed TOP values and MAX.
    localparam logic [15:0] TOP_MAX  = 16'hFFFF;
    localparam logic [15:0] TOP_8B   = 16'h00FF;
    localparam logic [15:0] TOP_9B   = 16'h01FF;
    localparam logic [15:0] TOP_10B  = 16'h03FF;
    // Noise filter needs this many equal samples.
    localparam int FILT_LEN = 4;
    // Waveform classes derived from the 4-bit mode.
    typedef enum logic [3:0] {
        WCTC_NONPWM = 4'h1,
        WCTC_FAST   = 4'h2,
        WCTC_DUAL   = 4'h4,
        WCTC_RSVD   = 4'h8
    } wctc_class_t;
endpackage

/* hdl/wctc_timer.sv */
// Timer/counter with waveform modes, compare outputs and input capture behind AHB-Lite.
//
// Functional notes
// - Nonzero output mode routes compare output to pin; code 01 leaves B unrouted outside modes 0,4,12 and A in modes 1-3 and 5-7.
// - Control A: out modes 7:6, 5:4, mode 1:0.
// - Non-PWM codes: off, toggle, clear, set.
// - Fast PWM code 01 toggles A in 14/15.
// - Fast PWM 10 clears match, sets TOP.
// - Fast PWM: compare equal TOP ignored, TOP action kept.
// - Dual-slope code 01 toggles A in 8-11.
// - Dual-slope 10 clears up, sets down.
// - Mode is four bits over two registers.
// - Modes 0,4,12: immediate update, overflow at MAX.
// - Fast PWM tops; buffers and overflow at TOP.
// - Modes 8,9: buffers and overflow at BOTTOM.
// - Phase-correct: load at TOP, overflow at BOTTOM.
// - Filter needs four equal samples when enabled.
// - Edge select: 0 falling, 1 rising.
// - Capture copies counter and sets capture flag.
// - Capture disabled when capture register is TOP.
// - Control A bits 3 and 2 read zero.
//
// Our own choices: register access over AHB-Lite and the register offsets.
module wctc_timer (
    input  wire logic        hclk,             // Bus and timer clock, 40 MHz.
    input  wire logic        hresetn,          // Asynchronous reset, active low.
    input  wire logic        hsel,             // Slave select.
    input  wire logic [31:0] haddr,            // Byte address.
    input  wire logic [1:0]  htrans,           // Transfer type.
    input  wire logic        hwrite,           // Write when high.
    input  wire logic [2:0]  hsize,            // Transfer size.
    input  wire logic [31:0] hwdata,           // Write data.
    input  wire logic        hready,           // Bus ready in.
    output logic      [31:0] hrdata,           // Read data.
    output logic             hreadyout,        // Slave ready, always high.
    output logic             hresp,            // Response, always OKAY.
    input  wire logic        capture_input_pin,// Capture pin, asynchronous.
    output logic             compare_output_a, // Waveform A level.
    output logic             compare_output_b, // Waveform B level.
    output logic             pin_route_a,      // Compare A owns its pin.
    output logic             pin_route_b       // Compare B owns its pin.
);
    logic [7:0]  ctrl_a_q, ctrl_b_q;
    logic [15:0] cmp_a_buf_q, cmp_b_buf_q, cmp_a_q, cmp_b_q;
    logic [15:0] counter_value_q, capture_value_q;
    logic [5:0]  flags_q;
    logic        down_q;
    logic        wr_q;
    logic [7:0]  wa_q;
    logic [3:0]  waveform_mode;
    logic [1:0]  out_mode_chan_a, out_mode_chan_b;
    wctc_pkg::wctc_class_t wclass;
    logic [15:0] top;
    logic        top_is_capt, top_is_cmpa, tick;
    logic        at_top, at_bot, load_buf, ovf_set;
    logic        match_a, match_b;
    logic        sync1_q, sync2_q, filt_q, filt_prev_q;
    logic [1:0]  filt_cnt_q;
    logic        capture_trigger;
    logic [9:0]  pre_cnt_q;

    assign out_mode_chan_a = ctrl_a_q[wctc_pkg::MODE_A_HI -: 2];
    assign out_mode_chan_b = ctrl_a_q[wctc_pkg::MODE_B_HI -: 2];
    assign waveform_mode   = {ctrl_b_q[wctc_pkg::WGM_H_HI -: 2], ctrl_a_q[1:0]};

    // Classifies a waveform mode; used for both the count logic and the outputs.
    function automatic wctc_pkg::wctc_class_t mode_class(input logic [3:0] m);
        unique case (m)
            4'd0, 4'd4, 4'd12:                  mode_class = wctc_pkg::WCTC_NONPWM;
            4'd5, 4'd6, 4'd7, 4'd14, 4'd15:     mode_class = wctc_pkg::WCTC_FAST;
            4'd13:                              mode_class = wctc_pkg::WCTC_RSVD;
            default:                            mode_class = wctc_pkg::WCTC_DUAL;
        endcase
    endfunction
    assign wclass = mode_class(waveform_mode);

    // TOP source per mode; mode 13 behaves as normal counting to MAX.
    always_comb
    begin
        top_is_capt = (waveform_mode == 4'd8) || (waveform_mode == 4'd10) ||
                      (waveform_mode == 4'd12) || (waveform_mode == 4'd14);
        top_is_cmpa = (waveform_mode == 4'd4) || (waveform_mode == 4'd9) ||
                      (waveform_mode == 4'd11) || (waveform_mode == 4'd15);
        case (waveform_mode)
            4'd1, 4'd5: top = wctc_pkg::TOP_8B;
            4'd2, 4'd6: top = wctc_pkg::TOP_9B;
            4'd3, 4'd7: top = wctc_pkg::TOP_10B;
            default:    top = top_is_capt ? capture_value_q :
                              (top_is_cmpa ? cmp_a_q : wctc_pkg::TOP_MAX);
        endcase
    end

    // Prescaler: 0 stops, 1..5 divide by 1, 8, 64, 256, 1024; external codes stop.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            pre_cnt_q <= 10'h000;
        else
            pre_cnt_q <= pre_cnt_q + 10'h001;
    end
    always_comb
    begin
        unique case (ctrl_b_q[wctc_pkg::PRE_HI -: 3])
            3'd1:    tick = 1'b1;
            3'd2:    tick = (pre_cnt_q[2:0] == 3'h7);
            3'd3:    tick = (pre_cnt_q[5:0] == 6'h3F);
            3'd4:    tick = (pre_cnt_q[7:0] == 8'hFF);
            3'd5:    tick = (pre_cnt_q == 10'h3FF);
            default: tick = 1'b0;
        endcase
    end

    // Update points: immediate, TOP or BOTTOM; overflow at MAX, TOP or BOTTOM.
    assign at_top   = (counter_value_q == top);
    assign at_bot   = (counter_value_q == 16'h0000);
    always_comb
    begin
        load_buf = 1'b0;
        ovf_set  = 1'b0;
        unique case (wclass)
            wctc_pkg::WCTC_NONPWM, wctc_pkg::WCTC_RSVD:
            begin
                load_buf = 1'b1;
                ovf_set  = tick && (counter_value_q == wctc_pkg::TOP_MAX);
            end
            wctc_pkg::WCTC_FAST:
            begin
                load_buf = tick && at_top;
                ovf_set  = tick && at_top;
            end
            wctc_pkg::WCTC_DUAL:
            begin
                load_buf = tick && ((waveform_mode[3:1] == 3'b100) ? at_bot : at_top);
                ovf_set  = tick && at_bot && down_q;
            end
        endcase
    end

    // Counter and direction.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            counter_value_q <= 16'h0000;
            down_q          <= 1'b0;
        end
        else if (wr_q && wa_q == wctc_pkg::COUNT_OFF)
            counter_value_q <= hwdata[15:0];
        else if (tick)
        begin
            if (wclass == wctc_pkg::WCTC_DUAL)
            begin
                if (at_top)
                begin
                    down_q          <= 1'b1;
                    counter_value_q <= counter_value_q - 16'h0001;
                end
                else if (at_bot && down_q)
                begin
                    down_q          <= 1'b0;
                    counter_value_q <= counter_value_q + 16'h0001;
                end
                else
                    counter_value_q <= down_q ? counter_value_q - 16'h0001 :
                                                counter_value_q + 16'h0001;
            end
            else
            begin
                down_q          <= 1'b0;
                counter_value_q <= at_top ? 16'h0000 : counter_value_q + 16'h0001;
            end
        end
    end

    // Compare buffers: software writes the buffer, the active value loads at the update point.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cmp_a_q <= 16'h0000;
            cmp_b_q <= 16'h0000;
        end
        else if (load_buf)
        begin
            cmp_a_q <= cmp_a_buf_q;
            cmp_b_q <= cmp_b_buf_q;
        end
    end

    // Compare matches; fast PWM ignores a match that equals TOP when the upper bit is set.
    assign match_a = tick && (counter_value_q == cmp_a_q) &&
                     !(wclass == wctc_pkg::WCTC_FAST && at_top && out_mode_chan_a[1]);
    assign match_b = tick && (counter_value_q == cmp_b_q) &&
                     !(wclass == wctc_pkg::WCTC_FAST && at_top && out_mode_chan_b[1]);

    // Next waveform level for one channel.
    function automatic logic wave_next(input logic cur, input logic [1:0] cm,
                                       input logic is_a, input logic m, input logic t,
                                       input logic dn, input wctc_pkg::wctc_class_t c,
                                       input logic [3:0] wm);
        wave_next = cur;
        unique case (c)
            wctc_pkg::WCTC_NONPWM, wctc_pkg::WCTC_RSVD:
                if (m)
                    wave_next = (cm == 2'b01) ? ~cur : cm[0];
            wctc_pkg::WCTC_FAST:
                if (cm == 2'b01)
                    wave_next = (is_a && wm[3:1] == 3'b111 && m) ? ~cur : cur;
                else if (t)
                    wave_next = ~cm[0];
                else if (m)
                    wave_next = cm[0];
            wctc_pkg::WCTC_DUAL:
                if (m && cm == 2'b01)
                    wave_next = (is_a && wm[3:2] == 2'b10) ? ~cur : cur;
                else if (m && cm[1])
                    wave_next = cm[0] ^ dn;
        endcase
    endfunction

    // Compare output levels.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            compare_output_a <= 1'b0;
            compare_output_b <= 1'b0;
        end
        else
        begin
            compare_output_a <= wave_next(compare_output_a, out_mode_chan_a, 1'b1, match_a,
                                          tick && at_top, down_q, wclass, waveform_mode);
            compare_output_b <= wave_next(compare_output_b, out_mode_chan_b, 1'b0, match_b,
                                          tick && at_top, down_q, wclass, waveform_mode);
        end
    end

    // Pin ownership; code 01 leaves B disconnected outside non-PWM modes and A disconnected outside toggle modes.
    assign pin_route_a = (out_mode_chan_a != 2'b00) &&
        !(out_mode_chan_a == 2'b01 && wclass == wctc_pkg::WCTC_FAST && waveform_mode[3:1] != 3'b111) &&
        !(out_mode_chan_a == 2'b01 && wclass == wctc_pkg::WCTC_DUAL && waveform_mode[3:2] != 2'b10);
    assign pin_route_b = (out_mode_chan_b != 2'b00) &&
        !(out_mode_chan_b == 2'b01 && wclass != wctc_pkg::WCTC_NONPWM);

    // Two-flop synchroniser; only the second stage feeds the filter.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end
        else
        begin
            sync1_q <= capture_input_pin;
            sync2_q <= sync1_q;
        end
    end

    // Noise filter: output follows input only after four equal samples when enabled.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            filt_q      <= 1'b0;
            filt_cnt_q  <= 2'h0;
            filt_prev_q <= 1'b0;
        end
        else
        begin
            filt_prev_q <= filt_q;
            if (!ctrl_b_q[wctc_pkg::FILT_BIT])
            begin
                filt_q     <= sync2_q;
                filt_cnt_q <= 2'h0;
            end
            else if (sync2_q == filt_q)
                filt_cnt_q <= 2'h0;
            else if (filt_cnt_q == 2'(wctc_pkg::FILT_LEN - 1))
            begin
                filt_q     <= sync2_q;
                filt_cnt_q <= 2'h0;
            end
            else
                filt_cnt_q <= filt_cnt_q + 2'h1;
        end
    end

    // Edge select chooses the trigger; capture is off while the capture register is TOP.
    assign capture_trigger = !top_is_capt &&
        (ctrl_b_q[wctc_pkg::EDGE_BIT] ? (filt_q && !filt_prev_q)
                                      : (!filt_q && filt_prev_q));

    // Registers and flags; a hardware set beats a same-cycle write-one clear.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctrl_a_q        <= wctc_pkg::CTRL_RESET;
            ctrl_b_q        <= wctc_pkg::CTRL_RESET;
            cmp_a_buf_q     <= 16'h0000;
            cmp_b_buf_q     <= 16'h0000;
            capture_value_q <= 16'h0000;
            flags_q         <= 6'h00;
        end
        else
        begin
            if (wr_q)
                unique case (wa_q)
                    wctc_pkg::CTRL_A_OFF:
                        ctrl_a_q <= hwdata[7:0] & wctc_pkg::CTRL_A_WMASK;
                    wctc_pkg::CTRL_B_OFF:
                        ctrl_b_q <= hwdata[7:0] & wctc_pkg::CTRL_B_WMASK;
                    wctc_pkg::CMP_A_OFF: cmp_a_buf_q <= hwdata[15:0];
                    wctc_pkg::CMP_B_OFF: cmp_b_buf_q <= hwdata[15:0];
                    wctc_pkg::CAPT_OFF:  capture_value_q <= hwdata[15:0];
                    default: ;
                endcase
            if (capture_trigger)
                capture_value_q <= counter_value_q;
            flags_q <= (flags_q & ~((wr_q && wa_q == wctc_pkg::FLAGS_OFF) ? hwdata[5:0] : 6'h00))
                     | {capture_trigger || (top_is_capt && tick && at_top), 2'b00,
                        match_b, match_a, ovf_set};
        end
    end

    // Bus slave: zero wait states, always OKAY; unmapped reads return zero.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_q <= 1'b0;
            wa_q <= 8'h00;
        end
        else
        begin
            wr_q <= hsel && hready && htrans[1] && hwrite;
            wa_q <= haddr[7:0];
        end
    end
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h0000_0000;
        else if (hsel && hready && htrans[1] && !hwrite)
            unique case (haddr[7:0])
                wctc_pkg::CTRL_A_OFF: hrdata <= {24'h0, ctrl_a_q};
                wctc_pkg::CTRL_B_OFF: hrdata <= {24'h0, ctrl_b_q};
                wctc_pkg::CMP_A_OFF:  hrdata <= {16'h0, cmp_a_buf_q};
                wctc_pkg::CMP_B_OFF:  hrdata <= {16'h0, cmp_b_buf_q};
                wctc_pkg::CAPT_OFF:   hrdata <= {16'h0, capture_value_q};
                wctc_pkg::COUNT_OFF:  hrdata <= {16'h0, counter_value_q};
                wctc_pkg::FLAGS_OFF:  hrdata <= {26'h0, flags_q};
                default:              hrdata <= 32'h0000_0000;
            endcase
    end

    // Checks and scenario covers.
    rsvd_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ctrl_a_q[3:2] == 2'b00 && !ctrl_b_q[5]) else $error("reserved bits set");
    capt_copy_a: assert property (@(posedge hclk) disable iff (!hresetn)
        capture_trigger |=> capture_value_q == $past(counter_value_q) && flags_q[5])
        else $error("capture copy missing");
    capt_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
        top_is_capt && !(wr_q && wa_q == wctc_pkg::CAPT_OFF) |=> $stable(capture_value_q))
        else $error("capture while top");
    route_b_a: assert property (@(posedge hclk) disable iff (!hresetn)
        out_mode_chan_b == 2'b00 |-> !pin_route_b) else $error("b routed");
    ovf_max_a: assert property (@(posedge hclk) disable iff (!hresetn)
        wclass == wctc_pkg::WCTC_NONPWM && tick && counter_value_q == 16'hFFFF
        |=> flags_q[0]) else $error("overflow missed");
    fast_clr_a: assert property (@(posedge hclk) disable iff (!hresetn)
        wclass == wctc_pkg::WCTC_FAST && out_mode_chan_a == 2'b10 && tick && at_top
        |=> compare_output_a) else $error("fast top set");
    nonpwm_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
        wclass == wctc_pkg::WCTC_NONPWM && out_mode_chan_a == 2'b11 && match_a
        |=> compare_output_a) else $error("set on match");
    dual_up_a: assert property (@(posedge hclk) disable iff (!hresetn)
        wclass == wctc_pkg::WCTC_DUAL && out_mode_chan_b == 2'b10 && match_b && !down_q
        |=> !compare_output_b) else $error("dual clear");
    cov_capt_c: cover property (@(posedge hclk) capture_trigger);
    cov_fast_c: cover property (@(posedge hclk) wclass == wctc_pkg::WCTC_FAST && at_top && tick);
    cov_dual_c: cover property (@(posedge hclk) ovf_set && wclass == wctc_pkg::WCTC_DUAL);
endmodule // wctc_timer

/* dv/wctc_pins.sv */
// Model of the pins around the timer: capture source and compare output pads.
module wctc_pins (
    input  wire logic hclk,              // Timer clock.
    output logic      capture_input_pin, // Capture source level.
    input  wire logic compare_output_a,  // Waveform A level.
    input  wire logic compare_output_b,  // Waveform B level.
    input  wire logic pin_route_a,       // Compare A owns pad A.
    input  wire logic pin_route_b,       // Compare B owns pad B.
    output logic      pad_a,             // Level seen on pad A.
    output logic      pad_b              // Level seen on pad B.
);
    timeunit 1ns;
    timeprecision 1ps;
    // Directions are set to output; an unrouted pad falls back to its pull-up.
    assign pad_a = pin_route_a ? compare_output_a : 1'b1;
    assign pad_b = pin_route_b ? compare_output_b : 1'b1;
    // The source idles low until a scenario moves it.
    initial capture_input_pin = 1'b0;
    // Moves the source; a nonzero length makes a pulse that then returns.
    task automatic drive(input logic lvl, input int len);
        capture_input_pin <= lvl;
        if (len > 0)
        begin
            repeat (len) @(posedge hclk);
            capture_input_pin <= ~lvl;
        end
    endtask
endmodule // wctc_pins

/* dv/tb.sv */
// Self-checking testbench for the timer control block.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, cap_pin;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        out_a, out_b, route_a, route_b, pad_a, pad_b;
    int          miscompares, comparisons, cycles;

    wctc_timer dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .capture_input_pin(cap_pin), .compare_output_a(out_a), .compare_output_b(out_b),
        .pin_route_a(route_a), .pin_route_b(route_b));
    wctc_pins pins (.hclk(hclk), .capture_input_pin(cap_pin), .compare_output_a(out_a),
        .compare_output_b(out_b), .pin_route_a(route_a), .pin_route_b(route_b),
        .pad_a(pad_a), .pad_b(pad_b));

    // Clock at 25 ns and idle bus values from time zero.
    initial
    begin
        hclk = 1'b0;
        hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'b00;
        hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0;
        forever #12.5 hclk = ~hclk;
    end

    // Cuts a hang short; the ceiling is well above the expected run.
    always @(posedge hclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 40000)
        begin
            miscompares++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One single transfer; entered just after a rising edge.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1; haddr <= {24'h0, a}; htrans <= 2'b10; hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0; htrans <= 2'b00; hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    // Reset values, reserved bits, pin ownership and an unmapped place.
    task automatic t_regs();
        rdc(wctc_pkg::CTRL_A_OFF, 32'h0);
        rdc(wctc_pkg::CTRL_B_OFF, 32'h0);
        wr(wctc_pkg::CTRL_A_OFF, 32'hFF);
        rdc(wctc_pkg::CTRL_A_OFF, 32'hF3);
        chk({route_a, route_b}, 2'b11);
        wr(wctc_pkg::CTRL_A_OFF, 32'h40);
        @(posedge hclk);
        chk({route_a, route_b}, 2'b10);
        wr(wctc_pkg::CTRL_A_OFF, 32'h10);
        @(posedge hclk);
        chk({route_a, route_b}, 2'b01);
        wr(wctc_pkg::CTRL_B_OFF, 32'hDF);
        rdc(wctc_pkg::CTRL_B_OFF, 32'hDF);
        wr(8'h1C, 32'hFFFF);
        rdc(8'h1C, 32'h0);
    endtask

    // Normal mode: set, clear and toggle on a match, compare value taken at once.
    task automatic t_nonpwm();
        logic [7:0] code [3] = '{8'hC0, 8'h80, 8'h40};
        logic       exp  [3] = '{1'b1, 1'b0, 1'b1};
        wr(wctc_pkg::CTRL_B_OFF, 32'h01);
        wr(wctc_pkg::CMP_A_OFF, 32'h0020);
        for (int i = 0; i < 3; i++)
        begin
            wr(wctc_pkg::CTRL_A_OFF, {24'h0, code[i]});
            wr(wctc_pkg::COUNT_OFF, 32'h0);
            repeat (64) @(posedge hclk);
            chk(pad_a, exp[i]);
        end
    endtask

    // High time of both outputs over 512 cycles; channel B mirrors A so both pads are judged.
    task automatic t_pwm();
        logic [7:0]  ca [5] = '{8'hA1, 8'hF1, 8'hA1, 8'hA1, 8'hF1};
        logic [7:0]  cb [5] = '{8'h09, 8'h09, 8'h09, 8'h01, 8'h01};
        logic [15:0] cm [5] = '{16'h00FF, 16'h00FF, 16'h0040, 16'h0040, 16'h0040};
        int          lo [5] = '{512, 0, 124, 120, 376};
        int          hi [5] = '{512, 0, 136, 136, 392};
        int          ones;
        int          ones_b;
        for (int i = 0; i < 5; i++)
        begin
            wr(wctc_pkg::CTRL_A_OFF, {24'h0, ca[i]});
            wr(wctc_pkg::CTRL_B_OFF, {24'h0, cb[i]});
            wr(wctc_pkg::CMP_A_OFF, {16'h0, cm[i]});
            wr(wctc_pkg::CMP_B_OFF, {16'h0, cm[i]});
            repeat (1100) @(posedge hclk);
            ones = 0;
            ones_b = 0;
            repeat (512)
            begin
                @(posedge hclk);
                ones += (pad_a === 1'b1) ? 1 : 0;
                ones_b += (pad_b === 1'b1) ? 1 : 0;
            end
            chk(ones >= lo[i] && ones <= hi[i], 32'h1);
            chk(ones_b >= lo[i] && ones_b <= hi[i], 32'h1);
        end
    endtask

    // Edge select, capture flag, noise filter and capture off when it sets TOP.
    task automatic t_capture();
        logic [7:0] cb  [6] = '{8'h41, 8'h41, 8'h01, 8'h01, 8'hC1, 8'hC1};
        logic       lvl [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
        int         len [6] = '{0, 0, 0, 0, 2, 8};
        logic       exp [6] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
        wr(wctc_pkg::CTRL_A_OFF, 32'h0);
        for (int i = 0; i < 6; i++)
        begin
            wr(wctc_pkg::CTRL_B_OFF, {24'h0, cb[i]});
            wr(wctc_pkg::FLAGS_OFF, 32'h20);
            pins.drive(lvl[i], len[i]);
            repeat (16) @(posedge hclk);
            bus(1'b0, wctc_pkg::FLAGS_OFF, 32'h0);
            chk(rd[wctc_pkg::FLAG_CAPT], exp[i]);
        end
        wr(wctc_pkg::CTRL_B_OFF, 32'h59);
        wr(wctc_pkg::CAPT_OFF, 32'h1234);
        pins.drive(1'b0, 0);
        repeat (8) @(posedge hclk);
        pins.drive(1'b1, 0);
        repeat (16) @(posedge hclk);
        rdc(wctc_pkg::CAPT_OFF, 32'h1234);
    endtask

    // Main sequence: reset for eight cycles, then the scenarios.
    initial
    begin
        miscompares = 0;
        comparisons = 0;
        cycles = 0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_regs();
        t_nonpwm();
        t_pwm();
        t_capture();
        give_verdict();
    end
endmodule // tb
